// [src/mit_timer.sv]
// Multifunction interval timer sequencer, functions one to four
`timescale 1ns/100ps
`default_nettype none
`include "mit_params.svh"
// How it works
// - Pause-first flasher: supply on starts first interval with output off, then on.
// - Both flashers alternate first and second intervals while supply stays present.
// - Pulse-first flasher: output on at supply, off after first, on after second.
// - Contact delay: contact closing starts first interval, output on at expiry.
// - Contact delay: contact opening starts second interval, output off at expiry.
// - Contact delay: opening during first interval discards count; next closure restarts.
// - Power shot: first interval, then output on for second interval, once.
// - Power shot: supply loss erases elapsed time; restart from beginning on return.
module mit_timer
	import mit_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    supply_present,
	input  wire logic                    contact_in,
	input  wire logic [`MIT_FN_W-1:0]    fn_select,
	input  wire logic [`MIT_CNT_W-1:0]   first_interval,
	input  wire logic [`MIT_CNT_W-1:0]   second_interval,
	output logic                         relay_on
);
	typedef struct packed
	{
		mit_state_t              st;
		logic [`MIT_CNT_W-1:0]   cnt;
		logic                    out;
		mit_fn_t                 fn;
	} mit_core_state_t;

	mit_core_state_t s_q;
	mit_core_state_t s_d;
	mit_sync_if      sync ();

	// Contact goes through two flops before any edge or level is used
	mit_contact_sync u_sync
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.contact_in (contact_in),
		.sync       (sync.src)
	);

	// An interval of n ticks expires on its nth counted cycle; zero acts as one tick
	function automatic logic expired(input logic [`MIT_CNT_W-1:0] cnt, input logic [`MIT_CNT_W-1:0] lim);
		expired = (cnt + `MIT_CNT_W'(1)) >= lim;
	endfunction : expired

	// Sequencer; function is latched at supply-on so a mid-run change waits for a cycle of supply
	always_comb
	begin
		s_d = s_q;
		if (!supply_present)
		begin
			s_d.st  = MIT_ST_IDLE;
			s_d.cnt = `MIT_CNT_RST;
			s_d.out = 1'b0;
			s_d.fn  = mit_fn_t'(fn_select);
		end
		else
		begin
			s_d.cnt = s_q.cnt + `MIT_CNT_W'(1);
			case (s_q.st)
				MIT_ST_IDLE:
				begin
					s_d.cnt = `MIT_CNT_RST;
					case (s_q.fn)
						MIT_FN_PAUSE_FIRST:
						begin
							s_d.st  = MIT_ST_FIRST;
							s_d.out = 1'b0;
						end
						MIT_FN_PULSE_FIRST:
						begin
							s_d.st  = MIT_ST_FIRST;
							s_d.out = 1'b1;
						end
						MIT_FN_POWER_SHOT:
						begin
							s_d.st  = MIT_ST_FIRST;
							s_d.out = 1'b0;
						end
						MIT_FN_CONTACT_DELAY:
						begin
							// Level, not edge, so a contact already closed at power-up still counts
							if (sync.contact_level)
								s_d.st = MIT_ST_FIRST;
							s_d.out = 1'b0;
						end
						default:
							s_d.st = MIT_ST_IDLE;
					endcase
				end
				MIT_ST_FIRST:
				begin
					if (s_q.fn == MIT_FN_CONTACT_DELAY && !sync.contact_level)
					begin
						s_d.st  = MIT_ST_IDLE;
						s_d.cnt = `MIT_CNT_RST;
					end
					else if (expired(s_q.cnt, first_interval))
					begin
						s_d.cnt = `MIT_CNT_RST;
						case (s_q.fn)
							MIT_FN_PULSE_FIRST:
							begin
								s_d.st  = MIT_ST_SECOND;
								s_d.out = 1'b0;
							end
							MIT_FN_CONTACT_DELAY:
							begin
								s_d.st  = MIT_ST_HOLD_ON;
								s_d.out = 1'b1;
							end
							default:
							begin
								s_d.st  = MIT_ST_SECOND;
								s_d.out = 1'b1;
							end
						endcase
					end
				end
				MIT_ST_HOLD_ON:
				begin
					s_d.cnt = `MIT_CNT_RST;
					if (!sync.contact_level)
						s_d.st = MIT_ST_SECOND;
				end
				MIT_ST_SECOND:
				begin
					// A re-closure during the off delay is ignored; the output still drops at expiry
					if (expired(s_q.cnt, second_interval))
					begin
						s_d.cnt = `MIT_CNT_RST;
						case (s_q.fn)
							MIT_FN_PAUSE_FIRST:
							begin
								s_d.st  = MIT_ST_FIRST;
								s_d.out = 1'b0;
							end
							MIT_FN_PULSE_FIRST:
							begin
								s_d.st  = MIT_ST_FIRST;
								s_d.out = 1'b1;
							end
							MIT_FN_CONTACT_DELAY:
							begin
								s_d.st  = MIT_ST_IDLE;
								s_d.out = 1'b0;
							end
							default:
							begin
								s_d.st  = MIT_ST_DONE;
								s_d.out = 1'b0;
							end
						endcase
					end
				end
				MIT_ST_DONE:
				begin
					s_d.cnt = `MIT_CNT_RST;
					s_d.out = 1'b0;
				end
				default:
				begin
					s_d.st  = MIT_ST_IDLE;
					s_d.cnt = `MIT_CNT_RST;
					s_d.out = 1'b0;
				end
			endcase
		end
	end

	// Synchronous reset to the idle, relay-off state
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_q.st  <= MIT_ST_IDLE;
			s_q.cnt <= `MIT_CNT_RST;
			s_q.out <= 1'b0;
			s_q.fn  <= MIT_FN_PAUSE_FIRST;
		end
		else
			s_q <= s_d;
	end

	assign relay_on = s_q.out;
endmodule : mit_timer
`default_nettype wire

// [inc/mit_params.svh]
// Constants for the multifunction interval timer
`ifndef MIT_PARAMS_SVH
`define MIT_PARAMS_SVH
`define MIT_CNT_W        32
`define MIT_FN_W         2
`define MIT_FN_PAUSE     2'h0
`define MIT_FN_PULSE     2'h1
`define MIT_FN_CONTACT   2'h2
`define MIT_FN_SHOT      2'h3
`define MIT_CNT_RST      32'h0000_0000
`define MIT_SYNC_RST     2'h0
`endif

// [inc/mit_pkg.sv]
// Types shared by the multifunction interval timer
package mit_pkg;
	typedef enum logic [1:0]
	{
		MIT_FN_PAUSE_FIRST,
		MIT_FN_PULSE_FIRST,
		MIT_FN_CONTACT_DELAY,
		MIT_FN_POWER_SHOT
	} mit_fn_t;

	typedef enum
	{
		MIT_ST_IDLE,
		MIT_ST_FIRST,
		MIT_ST_SECOND,
		MIT_ST_HOLD_ON,
		MIT_ST_DONE
	} mit_state_t;
endpackage : mit_pkg

// [inc/mit_sync_if.sv]
// Carrier between the contact synchroniser and the sequencer
`timescale 1ns/100ps
`default_nettype none
interface mit_sync_if;
	logic contact_level;
	logic contact_rise;
	logic contact_fall;
	modport src (output contact_level, output contact_rise, output contact_fall);
	modport dst (input contact_level, input contact_rise, input contact_fall);
endinterface : mit_sync_if
`default_nettype wire

// [src/mit_contact_sync.sv]
// Two-stage synchroniser and edge detector for the control contact
`timescale 1ns/100ps
`default_nettype none
`include "mit_params.svh"
module mit_contact_sync
	import mit_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  contact_in,
	mit_sync_if.src    sync
);
	typedef struct packed
	{
		logic [1:0] meta;
		logic       last;
	} mit_sync_state_t;

	mit_sync_state_t s_q;
	mit_sync_state_t s_d;

	// Only meta[1] is looked at by the edge logic; meta[0] feeds meta[1] alone
	always_comb
	begin
		s_d      = s_q;
		s_d.meta = {s_q.meta[0], contact_in};
		s_d.last = s_q.meta[1];
	end

	// Synchronous reset, cleared stages read as an open contact
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_q.meta <= `MIT_SYNC_RST;
			s_q.last <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign sync.contact_level = s_q.meta[1];
	assign sync.contact_rise  = s_q.meta[1] & ~s_q.last;
	assign sync.contact_fall  = ~s_q.meta[1] & s_q.last;
endmodule : mit_contact_sync
`default_nettype wire

// [test/mit_timer_assertions.sv]
// Port-level checks of the interval timer
`timescale 1ns/100ps
`default_nettype none
module mit_timer_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        supply_present,
	input wire logic        contact_in,
	input wire logic [1:0]  fn_select,
	input wire logic [31:0] first_interval,
	input wire logic [31:0] second_interval,
	input wire logic        relay_on
);
	logic [1:0]  fn_q;
	logic [31:0] run_q;
	logic        rel_q;
	logic        tog_q;
	logic        done_q;
	wire  [31:0] n1 = (first_interval == 32'h0) ? 32'h1 : first_interval;
	wire  [31:0] n2 = (second_interval == 32'h0) ? 32'h1 : second_interval;
	// Shadow function latch and relay run length; first run after supply is skipped as it includes idle
	always_ff @(posedge clk)
	begin
		fn_q <= !rst_n ? 2'h0 : (supply_present ? fn_q : fn_select);
		rel_q <= relay_on;
		run_q <= (relay_on != rel_q) ? 32'h1 : run_q + 32'h1;
		tog_q <= rst_n && supply_present && (tog_q || relay_on != rel_q);
		done_q <= rst_n && supply_present && (done_q || (fn_q == 2'h3 && rel_q && !relay_on));
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_off; !supply_present |=> !relay_on; endproperty
	property p_pulse; $rose(supply_present) && fn_q == 2'h1 |=> relay_on; endproperty
	property p_pause; $rose(supply_present) && fn_q inside {2'h0, 2'h3} |=> !relay_on; endproperty
	property p_run; tog_q && supply_present && relay_on != rel_q && fn_q != 2'h2 |-> run_q == n1 || run_q == n2;
	endproperty
	property p_close; $rose(relay_on) && fn_q == 2'h2 |-> $past(contact_in, 3) && $past(contact_in); endproperty
	property p_open; $fell(relay_on) && fn_q == 2'h2 && supply_present |-> !$past(contact_in, 3); endproperty
	property p_keep; relay_on && supply_present && fn_q == 2'h2 && contact_in |=> relay_on; endproperty
	property p_shot; done_q |-> !relay_on; endproperty
	a_off: assert property (p_off) else $error("relay on without supply");
	a_pulse: assert property (p_pulse) else $error("pulse first late");
	a_pause: assert property (p_pause) else $error("pause first starts on");
	a_run: assert property (p_run) else $error("phase length wrong");
	a_close: assert property (p_close) else $error("relay on without closure");
	a_open: assert property (p_open) else $error("relay off too early");
	a_keep: assert property (p_keep) else $error("relay dropped while closed");
	a_shot: assert property (p_shot) else $error("single shot repeated");
	c_cont: cover property ($rose(relay_on) && fn_q == 2'h2);
	c_shot: cover property ($rose(done_q));
	c_flash: cover property (tog_q && fn_q == 2'h0 && relay_on != rel_q);
endmodule : mit_timer_chk
bind mit_timer mit_timer_chk u_mit_timer_chk (.clk(clk), .rst_n(rst_n), .supply_present(supply_present),
	.contact_in(contact_in), .fn_select(fn_select), .first_interval(first_interval),
	.second_interval(second_interval), .relay_on(relay_on));
`default_nettype wire

// [test/mit_contact_model.sv]
// Control contact and relay coil on the far side of the timer
`timescale 1ns/100ps
`default_nettype none
module mit_contact_model (
	input  wire logic close_req,
	input  wire logic relay_on,
	output logic      contact_in,
	output int        pickups
);
	// Dry contact, no bounce: the bench owns the timing
	assign contact_in = close_req;
	// Coil pick-ups, so a repeated shot is visible
	initial pickups = 0;
	always @(posedge relay_on) pickups++;
endmodule : mit_contact_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the interval timer
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk = 1'b0, rst_n = 1'b0, sup = 1'b0, req = 1'b0, con, rel;
	logic [1:0]  fn = 2'h0;
	logic [31:0] n1 = 32'h2, n2 = 32'h3, seed = 32'hCAFE0CBF;
	int          miscompares = 0, n_compared = 0, pk, pk0;
	always #50 clk = ~clk;
	mit_timer u_mit_timer (.clk(clk), .rst_n(rst_n), .supply_present(sup), .contact_in(con), .fn_select(fn),
		.first_interval(n1), .second_interval(n2), .relay_on(rel));
	mit_contact_model u_mit_contact_model (.close_req(req), .relay_on(rel), .contact_in(con), .pickups(pk));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Relay level k cycles after supply rises; zero interval counts as one
	function automatic logic exp_rel(input logic [1:0] f, input int k, input logic [31:0] a, b);
		int p;
		a = (a == 32'h0) ? 32'h1 : a;
		b = (b == 32'h0) ? 32'h1 : b;
		p = (k - 1) % (a + b);
		// Contact function never picks up while the contact stays open
		if (f == 2'h2)
			return 1'b0;
		if (f == 2'h3)
			return (k > a) && (k <= a + b);
		return (p < a) ^ (f == 2'h0);
	endfunction : exp_rel
	task automatic chk(input logic [31:0] seen, exp, input string what);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// Power-cycle into function f, then follow the relay with the contact chattering, or held open for the contact function
	task automatic walk(input logic [1:0] f, input int len);
		sup = 1'b0;
		fn = f;
		tick(2);
		chk(rel, 32'h0, "relay unpowered");
		sup = 1'b1;
		for (int k = 1; k <= len; k++)
		begin
			req = seed[3] & (f != 2'h2);
			seed = lfsr(seed);
			tick(1);
			chk(rel, exp_rel(f, k, n1, n2), "relay walk");
		end
		$display("walk fn %0d done", f);
	endtask : walk
	// Edges until the relay reaches v, bounded
	task automatic wait_rel(input logic v, input int exp);
		int c;
		c = 0;
		while (rel !== v && c < 200)
		begin
			tick(1);
			c++;
		end
		chk(c, exp, "contact delay");
		if (c == 200)
			tally_and_finish();
	endtask : wait_rel
	initial
	begin
		tick(12);
		rst_n = 1'b1;
		walk(2'h1, 24);
		for (int i = 0; i < 9; i++)
		begin
			// Drop supply first so a running phase never sees its limit move
			sup = 1'b0;
			n1 = seed % 5;
			n2 = (seed >> 8) % 5;
			seed = lfsr(seed);
			walk((i % 3 == 2) ? 2'h3 : 2'(i % 3), 24);
		end
		walk(2'h3, 3);
		pk0 = pk;
		walk(2'h3, 24);
		chk(pk - pk0, 32'h1, "pickups");
		req = 1'b0;
		n1 = 32'h6;
		n2 = 32'h4;
		walk(2'h2, 3);
		req = 1'b1;
		tick(4);
		req = 1'b0;
		tick(6);
		chk(rel, 32'h0, "early open");
		req = 1'b1;
		wait_rel(1'b1, 9);
		tick(2);
		req = 1'b0;
		wait_rel(1'b0, 7);
		$display("contact test done");
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
